//--- rtl/ccs_pkg.sv
// Package for the control-input and minimum-mode strobe block.
// Assumes a single 40 MHz processor clock and synchronous active-high reset.
package ccs_pkg;
  // ----------------------------------------
  // Timing and widths
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 25;
  localparam int RESET_MIN_CYCLES = 4;
  localparam int SYNC_STAGES = 2;
  localparam logic [15:0] RESTART_POINT = 16'hfff0;
  localparam int BUS_KIND_W = 2;
  // ----------------------------------------
  // Bus cycle kinds and bus states
  // ----------------------------------------
  typedef enum logic [1:0] {
    CCS_CYC_READ = 2'b00,
    CCS_CYC_WRITE = 2'b01,
    CCS_CYC_IACK = 2'b10
  } ccs_cyc_t;
  typedef enum logic [2:0] {
    CCS_ST_IDLE = 3'b000,
    CCS_ST_FIRST = 3'b001,
    CCS_ST_SECOND = 3'b010,
    CCS_ST_THIRD = 3'b011,
    CCS_ST_WAIT = 3'b100,
    CCS_ST_FOURTH = 3'b101
  } ccs_bus_t;
  // Bus cycle request from the execution side
  typedef struct packed {
    logic valid;
    logic ioAccess;
    ccs_cyc_t kind;
  } ccs_req_t;
  // Pin group driven by the block; each pin but irqAckStrobeN has value and enable
  typedef struct packed {
    logic ioMem;
    logic ioMemOe;
    logic writeStrobeN;
    logic writeStrobeOe;
    logic irqAckStrobeN;
  } ccs_pins_t;
endpackage

//--- rtl/ccs_sync.sv
// Two flip-flop level synchroniser for one input pin.
// Assumes the input may change at any time relative to clk.
`timescale 1ns/1ps
module ccs_sync #(
  parameter logic RESET_VALUE = 1'b0
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic d,
  output logic q
);
  logic stage1;
  // First stage is read by the second stage only
  always_ff @(posedge clk) begin
    if (rst) begin
      stage1 <= RESET_VALUE;
      q <= RESET_VALUE;
    end else begin
      stage1 <= d;
      q <= stage1;
    end
  end
endmodule

//--- rtl/ccs_control.sv
// Control inputs and minimum-mode bus strobes of the processor core.
// Assumes ready comes pre-synchronised; only irq, test and nmi inputs may be asynchronous.
// ----------------------------------------
// ----------------------------------------
`timescale 1ns/1ps
module ccs_control
  import ccs_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic transferReady,
  input wire logic maskable_irq_in,
  input wire logic testInN,
  input wire logic nmiIn,
  input wire logic mode_select_strap,
  input wire logic holdAck,
  input wire logic irqEnable,
  input wire logic instrEnd,
  input wire logic waitForTest,
  input wire logic nmiServiced,
  input wire ccs_pkg::ccs_req_t busReq,
  output ccs_pkg::ccs_pins_t pins,
  output logic minMode,
  output logic irqTake,
  output logic nmiPending,
  output logic testStall,
  output logic cycleDone,
  output logic [15:0] restartAddr,
  output logic restartGo
);
  import ccs_pkg::*;

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  logic irqSync;
  logic testSync;
  logic nmiSync;
  logic nmiPrev;
  logic strapSeen;

  ccs_sync #(.RESET_VALUE(1'b0)) uIrq (
    .clk(clk), .rst(rst), .d(maskable_irq_in), .q(irqSync));
  ccs_sync #(.RESET_VALUE(1'b1)) uTest (
    .clk(clk), .rst(rst), .d(testInN), .q(testSync));
  ccs_sync #(.RESET_VALUE(1'b0)) uNmi (
    .clk(clk), .rst(rst), .d(nmiIn), .q(nmiSync));

  // ----------------------------------------
  // Interrupt and test decoding
  // ----------------------------------------
  wire nmiRise = nmiSync & ~nmiPrev;
  wire next_nmiPending = nmiRise | (nmiPending & ~nmiServiced);
  wire irqSeen = instrEnd & irqEnable & irqSync;
  wire next_testStall = waitForTest & testSync;

  // Strap is caught by a clocked process, never by the reset itself
  always_ff @(posedge clk) begin
    if (rst) begin
      nmiPrev <= 1'b0;
      nmiPending <= 1'b0;
      irqTake <= 1'b0;
      testStall <= 1'b0;
      strapSeen <= 1'b0;
      minMode <= 1'b0;
    end else begin
      nmiPrev <= nmiSync;
      nmiPending <= next_nmiPending;
      irqTake <= irqSeen;
      testStall <= next_testStall;
      strapSeen <= 1'b1;
      if (!strapSeen) begin
        minMode <= mode_select_strap;
      end
    end
  end

  // ----------------------------------------
  // Bus state sequencer
  // ----------------------------------------
  ccs_bus_t busState;
  ccs_bus_t next_busState;
  ccs_cyc_t curKind;
  logic curIo;

  wire inStrobeState = (next_busState == CCS_ST_SECOND) |
                       (next_busState == CCS_ST_THIRD) |
                       (next_busState == CCS_ST_WAIT);

  always_comb begin
    next_busState = busState;
    case (busState)
      CCS_ST_IDLE: begin
        if (busReq.valid && !holdAck) begin
          next_busState = CCS_ST_FIRST;
        end
      end
      CCS_ST_FIRST: next_busState = CCS_ST_SECOND;
      CCS_ST_SECOND: next_busState = CCS_ST_THIRD;
      CCS_ST_THIRD, CCS_ST_WAIT: begin
        // Ready low keeps the cycle in wait states
        next_busState = transferReady ? CCS_ST_FOURTH : CCS_ST_WAIT;
      end
      CCS_ST_FOURTH: begin
        next_busState = (busReq.valid && !holdAck) ? CCS_ST_FIRST
                                                   : CCS_ST_IDLE;
      end
      default: next_busState = CCS_ST_IDLE;
    endcase
  end

  wire startCycle = next_busState == CCS_ST_FIRST;
  wire next_write = inStrobeState & (curKind == CCS_CYC_WRITE) & minMode;
  wire next_iack = inStrobeState & (curKind == CCS_CYC_IACK) & minMode;
  // Status line takes the new value in the idle or fourth state before the cycle
  wire loadIo = busReq.valid &&
                (busState == CCS_ST_IDLE || busState == CCS_ST_FOURTH);

  // Reset drops any cycle in progress at once
  always_ff @(posedge clk) begin
    if (rst) begin
      busState <= CCS_ST_IDLE;
      curKind <= CCS_CYC_READ;
      curIo <= 1'b0;
    end else begin
      busState <= next_busState;
      if (startCycle) begin
        curKind <= busReq.kind;
      end
      if (loadIo) begin
        curIo <= busReq.ioAccess;
      end
    end
  end

  // ----------------------------------------
  // Output pins, all registered
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      pins.ioMem <= 1'b1;
      pins.ioMemOe <= 1'b0;
      pins.writeStrobeN <= 1'b1;
      pins.writeStrobeOe <= 1'b0;
      pins.irqAckStrobeN <= 1'b1;
      cycleDone <= 1'b0;
      restartAddr <= RESTART_POINT;
      restartGo <= 1'b0;
    end else begin
      // Pins floated by hold keep a logic one so the bus-hold sees high
      pins.ioMem <= holdAck ? 1'b1 : (loadIo ? busReq.ioAccess : curIo);
      pins.ioMemOe <= ~holdAck & minMode;
      pins.writeStrobeN <= holdAck | ~next_write;
      pins.writeStrobeOe <= ~holdAck & minMode;
      pins.irqAckStrobeN <= ~next_iack;
      cycleDone <= next_busState == CCS_ST_FOURTH;
      restartAddr <= RESTART_POINT;
      restartGo <= ~strapSeen;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_wait_holds: assert property (@(posedge clk) disable iff (rst)
    (busState == CCS_ST_THIRD && !transferReady) |=> busState == CCS_ST_WAIT)
    else $error("ready low did not insert a wait state");
  a_ready_ends: assert property (@(posedge clk) disable iff (rst)
    (busState == CCS_ST_WAIT && transferReady) |=> busState == CCS_ST_FOURTH)
    else $error("ready high did not end the cycle");
  a_irq_masked: assert property (@(posedge clk) disable iff (rst)
    (instrEnd && !irqEnable) |=> !irqTake)
    else $error("masked request was taken");
  a_irq_taken: assert property (@(posedge clk) disable iff (rst)
    (instrEnd && irqEnable && irqSync) |=> irqTake)
    else $error("enabled request was missed");
  a_nmi_latch: assert property (@(posedge clk) disable iff (rst)
    (nmiSync && !$past(nmiSync)) |=> nmiPending)
    else $error("rising edge not remembered");
  a_nmi_stays: assert property (@(posedge clk) disable iff (rst)
    (nmiPending && !nmiServiced) |=> nmiPending)
    else $error("pending request lost before service");
  a_test_idle: assert property (@(posedge clk) disable iff (rst)
    (waitForTest && testSync) |=> testStall)
    else $error("idle not held with test high");
  a_write_hold: assert property (@(posedge clk) disable iff (rst)
    holdAck |=> (pins.writeStrobeN && !pins.writeStrobeOe && pins.ioMem))
    else $error("strobe driven during hold");
  a_write_states: assert property (@(posedge clk) disable iff (rst)
    (!pins.writeStrobeN) |-> (busState inside {CCS_ST_SECOND,
      CCS_ST_THIRD, CCS_ST_WAIT} && curKind == CCS_CYC_WRITE))
    else $error("write strobe outside its states");
  a_iack_states: assert property (@(posedge clk) disable iff (rst)
    (!pins.irqAckStrobeN) |-> (busState inside {CCS_ST_SECOND,
      CCS_ST_THIRD, CCS_ST_WAIT} && curKind == CCS_CYC_IACK))
    else $error("acknowledge strobe outside its states");
  a_reset_abort: assert property (@(posedge clk)
    rst |=> (busState == CCS_ST_IDLE && pins.writeStrobeN))
    else $error("reset did not abandon cycle");

  c_wait_cycle: cover property (@(posedge clk) disable iff (rst)
    busState == CCS_ST_WAIT ##1 busState == CCS_ST_FOURTH);
  c_write_cycle: cover property (@(posedge clk) disable iff (rst)
    !pins.writeStrobeN);
  c_iack_cycle: cover property (@(posedge clk) disable iff (rst)
    !pins.irqAckStrobeN);
  c_nmi_edge: cover property (@(posedge clk) disable iff (rst) nmiRise);
endmodule

//--- test/ccs_bus_partner.sv
// Far-side model: memory or I/O that answers with the ready line.
// Assumes the bench sets the wait count at a clock edge.
`timescale 1ns/1ps
module ccs_bus_partner (
  input wire logic clk,
  input wire logic rst,
  input wire ccs_pkg::ccs_pins_t pins,
  input wire logic [3:0] waitCnt,
  output logic transferReady
);
  import ccs_pkg::*;
  logic [3:0] cnt;
  // Ready only moves at clock edges, as the clock generator delivers it
  always_ff @(posedge clk) begin
    if (rst || transferReady) cnt <= 4'h0;
    else cnt <= cnt + 4'h1;
  end
  assign transferReady = (cnt >= waitCnt);
endmodule

//--- test/ccs_control_tb.sv
// Self-checking bench for the control-input and strobe block.
// Assumes ccs_bus_partner stands for the memory and I/O side.
`timescale 1ns/1ps
module ccs_control_tb;
  import ccs_pkg::*;
  logic clk = 0, rst = 1, maskable_irq_in = 0, testInN = 1, nmiIn = 0;
  logic holdAck = 0, irqEnable = 0, instrEnd = 0, waitForTest = 0;
  logic nmiServiced = 0, transferReady, minMode, irqTake, nmiPending;
  logic testStall, cycleDone, restartGo, ioSeen;
  logic [15:0] restartAddr;
  logic [3:0] waitCnt = 4'h0;
  logic [2:0] expQ[$];
  ccs_req_t busReq = '0;
  ccs_pins_t pins;
  int failures = 0, n_compared = 0, nWr, nAck, nTake = 0, nDone = 0;
  int seed = 80051;
  initial forever #12.5 clk = ~clk;
  ccs_control dut (.clk(clk), .rst(rst), .transferReady(transferReady),
    .maskable_irq_in(maskable_irq_in), .testInN(testInN), .nmiIn(nmiIn),
    .mode_select_strap(1'b1), .holdAck(holdAck), .irqEnable(irqEnable),
    .instrEnd(instrEnd), .waitForTest(waitForTest),
    .nmiServiced(nmiServiced), .busReq(busReq), .pins(pins),
    .minMode(minMode), .irqTake(irqTake), .nmiPending(nmiPending),
    .testStall(testStall), .cycleDone(cycleDone),
    .restartAddr(restartAddr), .restartGo(restartGo));
  ccs_bus_partner far (.clk(clk), .rst(rst), .pins(pins),
    .waitCnt(waitCnt), .transferReady(transferReady));
  task automatic check(input string what, input logic [15:0] e, a);
    n_compared++;
    if (e !== a) begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, e, a);
    end
  endtask
  task automatic test_done;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // Strobe widths are counted, since pins follow the bus state in the same cycle
  always @(negedge clk) begin
    if (rst) begin
      nWr = 0;
      nAck = 0;
      ioSeen = 0;
    end else begin
      if (pins.writeStrobeN === 1'b0) nWr++;
      if (pins.irqAckStrobeN === 1'b0) nAck++;
      if (!pins.writeStrobeN || !pins.irqAckStrobeN) ioSeen = pins.ioMem;
      if (irqTake === 1'b1) nTake++;
      if (cycleDone === 1'b1) begin
        nDone++;
        if (expQ.size() == 0) expQ.push_back(3'bxxx);
        check("cycle", expQ.pop_front(), {nWr > 1, nAck > 1, ioSeen});
        nWr = 0;
        nAck = 0;
        ioSeen = 0;
      end
    end
  end
  task automatic do_reset(input int n);
    @(posedge clk);
    rst <= 1'b1;
    expQ.delete();
    repeat (n) @(posedge clk);
    check("rstPins", 16'h2, {pins.writeStrobeN, pins.writeStrobeOe});
    rst <= 1'b0;
    // The restart pulse stands only between the first and second edges
    repeat (1) @(posedge clk);
    @(negedge clk);
    check("restartGo", 16'h1, 16'(restartGo));
    check("restartAddr", RESTART_POINT, restartAddr);
    check("minMode", 16'h1, 16'(minMode));
  endtask
  task automatic bus(input ccs_cyc_t k, input logic io, input logic [3:0] w);
    int i;
    logic ioLine;
    ioLine = io || (k == CCS_CYC_IACK);
    @(posedge clk);
    waitCnt <= w;
    busReq <= '{1'b1, ioLine, k};
    expQ.push_back({k == CCS_CYC_WRITE, k == CCS_CYC_IACK,
      ioLine && (k != CCS_CYC_READ)});
    @(posedge clk);
    busReq.valid <= 1'b0;
    for (i = 0; i < 40 && cycleDone !== 1'b1; i++) @(negedge clk);
    check("done", 16'h1, 16'(cycleDone));
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    do_reset(16);
    for (int i = 0; i < 12; i++) begin
      bus(ccs_cyc_t'(i % 3), 1'($random(seed)), 4'($random(seed) & 3));
    end
    @(posedge clk);
    holdAck <= 1'b1;
    nDone = 0;
    busReq <= '{1'b1, 1'b1, CCS_CYC_WRITE};
    repeat (8) @(posedge clk);
    busReq.valid <= 1'b0;
    check("hold", 16'h1, {pins.ioMemOe, pins.writeStrobeOe, pins.irqAckStrobeN});
    check("holdDone", 16'h0, 16'(nDone));
    holdAck <= 1'b0;
    maskable_irq_in <= 1'b1;
    for (int en = 0; en < 2; en++) begin
      @(posedge clk);
      irqEnable <= en[0];
      nTake = 0;
      repeat (4) @(posedge clk);
      instrEnd <= 1'b1;
      @(posedge clk);
      instrEnd <= 1'b0;
      repeat (4) @(posedge clk);
      check("irqTake", 16'(en), 16'(nTake));
    end
    maskable_irq_in <= 1'b0;
    irqEnable <= 1'b0;
    nmiIn <= 1'b1;
    repeat (12) @(posedge clk);
    check("nmiHeld", 16'h1, 16'(nmiPending));
    nmiServiced <= 1'b1;
    @(posedge clk);
    nmiServiced <= 1'b0;
    repeat (3) @(posedge clk);
    check("nmiClr", 16'h0, 16'(nmiPending));
    waitForTest <= 1'b1;
    repeat (6) @(posedge clk);
    check("stall", 16'h1, 16'(testStall));
    testInN <= 1'b0;
    repeat (6) @(posedge clk);
    check("go", 16'h0, 16'(testStall));
    waitForTest <= 1'b0;
    waitCnt <= 4'hf;
    busReq <= '{1'b1, 1'b0, CCS_CYC_WRITE};
    @(posedge clk);
    busReq.valid <= 1'b0;
    repeat (5) @(posedge clk);
    do_reset(4);
    bus(CCS_CYC_WRITE, 1'b1, 4'h0);
    test_done();
  end
  initial begin
    repeat (3000) @(posedge clk);
    failures++;
    test_done();
  end
endmodule
